// ---- inc/dfd_map.svh ----
// constants for the digital input function decoder
// assumes inclusion by the package, design and bench files
`ifndef DFD_MAP_SVH
`define DFD_MAP_SVH
`define DFD_N_TERM 9
`define DFD_FUNC_W 6
`define DFD_FN_FREQ_NORMAL 6'h0b
`define DFD_FN_WRITE_EN 6'h13
`define DFD_FN_PID_CANCEL 6'h14
`define DFD_FN_INVERSE 6'h15
`define DFD_FN_INTERLOCK 6'h16
`define DFD_FN_TORQUE_CANCEL 6'h17
`define DFD_FN_LINK_EN 6'h18
`define DFD_FN_UNIVERSAL 6'h19
`define DFD_FN_PICKUP 6'h1a
`define DFD_FN_STOP_NORMAL 6'h1e
`define DFD_FN_STOP_FOURTH 6'h1f
`define DFD_FN_FREQ_INVERTED 6'h23
`define DFD_STOP_HOLD_US 4000
`define DFD_CLK_MHZ 20
`define DFD_STOP_HOLD_CYC (`DFD_STOP_HOLD_US * `DFD_CLK_MHZ)
`endif

// ---- inc/dfd_pkg.sv ----
// types for the digital input function decoder
// assumes dfd_map.svh on the include path
`include "dfd_map.svh"
package dfd_pkg;
    typedef enum logic [1:0] {
        DFD_RAMP_NONE = 2'b00,
        DFD_RAMP_NORMAL = 2'b01,
        DFD_RAMP_FOURTH = 2'b11
    } dfd_ramp_t;
    typedef enum logic [1:0] {
        DFD_ST_IDLE = 2'b00,
        DFD_ST_DECEL = 2'b01,
        DFD_ST_HELD = 2'b11
    } dfd_stop_t;
endpackage : dfd_pkg

// ---- hdl/dfd_sync.sv ----
// three-stage pin synchroniser with second/third agreement filter
// assumes inputs are asynchronous to CORE_CLK
`timescale 1ns/1ps
module dfd_sync #(
    parameter int WIDTH = 9,
    parameter logic [0:0] RESET_LEVEL = 1'b0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;
    wire [WIDTH-1:0] agree = ~(s2_q ^ s3_q);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= {WIDTH{RESET_LEVEL}};
            s2_q <= {WIDTH{RESET_LEVEL}};
            s3_q <= {WIDTH{RESET_LEVEL}};
            lvl_q <= {WIDTH{RESET_LEVEL}};
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            lvl_q <= (agree & s3_q) | (~agree & lvl_q);
        end
    end
    assign level = lvl_q;
endmodule : dfd_sync

// ---- hdl/dfd_decoder.sv ----
// input terminal function decoder: per-terminal function codes gate drive behaviour
// assumes terminal pins asynchronous; function codes and settings static from core logic
`timescale 1ns/1ps
`include "dfd_map.svh"
// Summary of operation
// - keypad write allowed only while write-enable input is on or unassigned
// - closed-loop cancel on selects keypad frequency instead of closed loop
// - inverse-mode input on inverts analog forward/inverse sense
// - inverse-mode input ignored when closed-loop mode is 1 or 2
// - interlock input on supplies momentary power-failure detection
// - with torque control, cancel input moves voltage input to frequency or feedback
// - link commands accepted only while link-enable input is on or unassigned
// - universal input state readable over link, no drive effect
// - pick-up start enabled while its input is on
// - forced-stop active low; going off while running decelerates and alarms
// - second forced-stop uses fourth deceleration time
// - forced stop overrides every command source
// - ramp may stretch under torque limit or regeneration avoidance
// - inverted source select: off second method, on first method
// - both source selects assigned gives configuration error
// - normal source select: off first method, on second method
module dfd_decoder
    import dfd_pkg::*;
#(
    parameter int N_TERM = `DFD_N_TERM,
    parameter int STOP_HOLD_CYC = `DFD_STOP_HOLD_CYC
) (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic CLK_EN,
    input wire logic [N_TERM-1:0] TERM_IN,
    input wire logic [N_TERM*`DFD_FUNC_W-1:0] TERM_FUNC,
    input wire logic [1:0] CLOSED_LOOP_MODE,
    input wire logic [1:0] TORQUE_CONTROL_MODE,
    input wire logic MOTOR_RUNNING,
    input wire logic DECEL_LIMIT_ACTIVE,
    input wire logic KEYPAD_WRITE_REQ,
    input wire logic LINK_CMD_REQ,
    output logic KEYPAD_WRITE_OK,
    output logic CLOSED_LOOP_ACTIVE,
    output logic ANALOG_INVERT,
    output logic IPF_DETECT_EXT,
    output logic IPF_DETECT_USE,
    output logic VIN_IS_TORQUE_CMD,
    output logic VIN_IS_FEEDBACK,
    output logic LINK_CMD_OK,
    output logic [N_TERM-1:0] UNIVERSAL_READ,
    output logic PICKUP_START_EN,
    output logic FORCED_STOP,
    output logic FOURTH_RAMP_SEL,
    output logic RAMP_STRETCH_OK,
    output logic CMD_SOURCE_BLOCK,
    output logic SECOND_FREQ_SEL,
    output logic CONFIG_STOP_ALARM
);
    if (N_TERM < 1 || N_TERM > 32) begin : g_bad_nterm
        $error("N_TERM out of range");
    end
    if (STOP_HOLD_CYC < 1) begin : g_bad_hold
        $error("STOP_HOLD_CYC must be positive");
    end

    logic [N_TERM-1:0] lvl;
    dfd_sync #(.WIDTH(N_TERM), .RESET_LEVEL(1'b0)) u_sync (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .ce(CLK_EN),
        .pin(TERM_IN),
        .level(lvl)
    );

    // per-terminal decode: assigned mask for each function
    logic [N_TERM-1:0] a_we, a_pid, a_ivs, a_il, a_trq, a_le, a_ud, a_stm, a_s1, a_s2, a_fn, a_fi;
    genvar g;
    generate
        for (g = 0; g < N_TERM; g++) begin : g_term
            wire [`DFD_FUNC_W-1:0] fc = TERM_FUNC[g*`DFD_FUNC_W +: `DFD_FUNC_W];
            assign a_we[g] = (fc == `DFD_FN_WRITE_EN);
            assign a_pid[g] = (fc == `DFD_FN_PID_CANCEL);
            assign a_ivs[g] = (fc == `DFD_FN_INVERSE);
            assign a_il[g] = (fc == `DFD_FN_INTERLOCK);
            assign a_trq[g] = (fc == `DFD_FN_TORQUE_CANCEL);
            assign a_le[g] = (fc == `DFD_FN_LINK_EN);
            assign a_ud[g] = (fc == `DFD_FN_UNIVERSAL);
            assign a_stm[g] = (fc == `DFD_FN_PICKUP);
            assign a_s1[g] = (fc == `DFD_FN_STOP_NORMAL);
            assign a_s2[g] = (fc == `DFD_FN_STOP_FOURTH);
            assign a_fn[g] = (fc == `DFD_FN_FREQ_NORMAL);
            assign a_fi[g] = (fc == `DFD_FN_FREQ_INVERTED);
        end
    endgenerate

    // an unassigned function behaves as its inactive default, except write enable and link enable, which act as on
    wire we_on = ~|a_we | |(a_we & lvl);
    wire pid_cancel = |(a_pid & lvl);
    wire ivs_on = |(a_ivs & lvl);
    wire il_assigned = |a_il;
    wire il_on = |(a_il & lvl);
    wire trq_cancel = |(a_trq & lvl);
    wire le_on = ~|a_le | |(a_le & lvl);
    wire stm_on = |(a_stm & lvl);
    // forced-stop inputs are active low: any assigned terminal off requests stop
    wire s1_req = |(a_s1 & ~lvl);
    wire s2_req = |(a_s2 & ~lvl);
    wire both_sel = |a_fn & |a_fi;
    wire fn_on = |(a_fn & lvl);
    wire fi_on = |(a_fi & lvl);
    wire cl_sel = (CLOSED_LOOP_MODE == 2'd1) || (CLOSED_LOOP_MODE == 2'd2);
    wire tq_sel = (TORQUE_CONTROL_MODE == 2'd1) || (TORQUE_CONTROL_MODE == 2'd2);
    wire cl_run = cl_sel & ~pid_cancel;
    wire second_d = |a_fn ? fn_on : (|a_fi ? ~fi_on : 1'b0);

    dfd_stop_t st_q, st_d;
    dfd_ramp_t ramp_q, ramp_d;
    logic [31:0] hold_q, hold_d;
    logic alarm_q;
    logic [N_TERM-1:0] ud_q;
    logic kw_q;
    logic ac_q;
    logic ai_q;
    logic ipf_q;
    logic ipu_q;
    logic vt_q;
    logic vf_q;
    logic lk_q;
    logic pk_q;
    logic sf_q;

    wire stop_req = s1_req | s2_req;
    // fourth ramp wins when both stop inputs are off, as it is the dedicated one
    wire [1:0] ramp_sel = s2_req ? DFD_RAMP_FOURTH : DFD_RAMP_NORMAL;
    wire hold_done = (hold_q >= 32'(STOP_HOLD_CYC - 1));

    always_comb begin
        st_d = st_q;
        ramp_d = ramp_q;
        hold_d = hold_q;
        unique case (st_q)
            DFD_ST_IDLE: begin
                if (stop_req && MOTOR_RUNNING) begin
                    st_d = DFD_ST_DECEL;
                    ramp_d = dfd_ramp_t'(ramp_sel);
                    hold_d = 32'd0;
                end
            end
            DFD_ST_DECEL: begin
                if (stop_req && !hold_done) begin
                    hold_d = hold_q + 32'd1;
                end
                if (s2_req) begin
                    ramp_d = DFD_RAMP_FOURTH;
                end
                if (!stop_req && !MOTOR_RUNNING) begin
                    st_d = DFD_ST_HELD;
                end
            end
            DFD_ST_HELD: begin
                st_d = DFD_ST_IDLE;
                ramp_d = DFD_RAMP_NONE;
            end
            default: begin
                st_d = DFD_ST_IDLE;
                ramp_d = DFD_RAMP_NONE;
            end
        endcase
    end

    wire stopping = (st_q == DFD_ST_DECEL);
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_q <= DFD_ST_IDLE;
            ramp_q <= DFD_RAMP_NONE;
            hold_q <= 32'd0;
            alarm_q <= 1'b0;
            ud_q <= '0;
            kw_q <= 1'b0;
            ac_q <= 1'b0;
            ai_q <= 1'b0;
            ipf_q <= 1'b0;
            ipu_q <= 1'b0;
            vt_q <= 1'b0;
            vf_q <= 1'b0;
            lk_q <= 1'b0;
            pk_q <= 1'b0;
            sf_q <= 1'b0;
        end else if (CLK_EN) begin
            st_q <= st_d;
            ramp_q <= ramp_d;
            hold_q <= hold_d;
            // alarm stays until reset; the drive has no clear path here
            alarm_q <= alarm_q | both_sel | (stop_req & MOTOR_RUNNING);
            ud_q <= a_ud & lvl;
            kw_q <= KEYPAD_WRITE_REQ & we_on;
            ac_q <= cl_run;
            ai_q <= ivs_on & ~cl_sel;
            ipf_q <= il_assigned & il_on;
            ipu_q <= il_assigned;
            vt_q <= tq_sel & ~trq_cancel;
            vf_q <= tq_sel & trq_cancel & cl_run;
            // stop blocks link commands too, whatever the link enable says
            lk_q <= LINK_CMD_REQ & le_on & ~stop_req & ~stopping;
            pk_q <= stm_on;
            sf_q <= second_d;
        end
    end

    assign KEYPAD_WRITE_OK = kw_q;
    assign CLOSED_LOOP_ACTIVE = ac_q;
    assign ANALOG_INVERT = ai_q;
    assign IPF_DETECT_EXT = ipf_q;
    assign IPF_DETECT_USE = ipu_q;
    assign VIN_IS_TORQUE_CMD = vt_q;
    assign VIN_IS_FEEDBACK = vf_q;
    assign LINK_CMD_OK = lk_q;
    assign UNIVERSAL_READ = ud_q;
    assign PICKUP_START_EN = pk_q;
    assign FORCED_STOP = stopping;
    assign FOURTH_RAMP_SEL = (ramp_q == DFD_RAMP_FOURTH);
    assign RAMP_STRETCH_OK = stopping & DECEL_LIMIT_ACTIVE;
    assign CMD_SOURCE_BLOCK = stopping | stop_req;
    assign SECOND_FREQ_SEL = sf_q;
    assign CONFIG_STOP_ALARM = alarm_q;
endmodule : dfd_decoder

// ---- bench/dfd_decoder_chk.sv ----
// assertions on the input function decoder outputs
// assumes bind to dfd_decoder, single clock domain
`timescale 1ns/1ps
module dfd_decoder_chk (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic [1:0] CLOSED_LOOP_MODE,
    input wire logic [1:0] TORQUE_CONTROL_MODE,
    input wire logic MOTOR_RUNNING,
    input wire logic DECEL_LIMIT_ACTIVE,
    input wire logic KEYPAD_WRITE_REQ,
    input wire logic LINK_CMD_REQ,
    input wire logic KEYPAD_WRITE_OK,
    input wire logic CLOSED_LOOP_ACTIVE,
    input wire logic ANALOG_INVERT,
    input wire logic VIN_IS_TORQUE_CMD,
    input wire logic VIN_IS_FEEDBACK,
    input wire logic LINK_CMD_OK,
    input wire logic FORCED_STOP,
    input wire logic RAMP_STRETCH_OK,
    input wire logic CMD_SOURCE_BLOCK,
    input wire logic CONFIG_STOP_ALARM
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);
    AST_KEYPAD_GATE: assert property (KEYPAD_WRITE_OK |-> $past(KEYPAD_WRITE_REQ))
        else $error("keypad write allowed without request");
    AST_LOOP_MODE: assert property (CLOSED_LOOP_ACTIVE |-> $past(CLOSED_LOOP_MODE) inside {2'h1, 2'h2})
        else $error("closed loop active while not selected");
    AST_INVERSE_GATE: assert property (ANALOG_INVERT |-> !($past(CLOSED_LOOP_MODE) inside {2'h1, 2'h2}))
        else $error("analog invert while closed loop selected");
    AST_FEEDBACK: assert property (VIN_IS_FEEDBACK |-> CLOSED_LOOP_ACTIVE && !VIN_IS_TORQUE_CMD)
        else $error("voltage input feedback without closed loop");
    AST_LINK_GATE: assert property (LINK_CMD_OK |-> $past(LINK_CMD_REQ) && !$past(FORCED_STOP))
        else $error("link command passed while stopping or idle");
    AST_STOP_START: assert property ($rose(FORCED_STOP) |-> CONFIG_STOP_ALARM && $past(MOTOR_RUNNING))
        else $error("forced stop without alarm or running motor");
    AST_STOP_PRIORITY: assert property (FORCED_STOP |-> CMD_SOURCE_BLOCK && !LINK_CMD_OK)
        else $error("command source not blocked during stop");
    AST_STRETCH: assert property (RAMP_STRETCH_OK == (FORCED_STOP && DECEL_LIMIT_ACTIVE))
        else $error("ramp stretch flag wrong");
    AST_ALARM_HOLD: assert property (CONFIG_STOP_ALARM |=> CONFIG_STOP_ALARM [*3])
        else $error("alarm dropped before reset");
    COV_STOP: cover property ($rose(FORCED_STOP));
    COV_FEEDBACK: cover property (VIN_IS_FEEDBACK);
    COV_INVERT: cover property (ANALOG_INVERT && TORQUE_CONTROL_MODE == 2'h1);
endmodule : dfd_decoder_chk

// ---- bench/dfd_ctl.sv ----
// terminal driver standing in for the external controller
// assumes want changes at clock edges; pin 8 is the forced-stop terminal
`timescale 1ns/1ps
module dfd_ctl #(
    parameter int HOLD = 8
) (
    input wire logic clk,
    input wire logic [8:0] want,
    output logic [8:0] term
);
    logic [8:0] pin_q = 9'h100;
    int cnt_q = 0;
    assign term = pin_q;
    always @(posedge clk) begin
        pin_q[7:0] <= want[7:0];
        // a short stop pulse is stretched, the device may miss anything shorter
        pin_q[8] <= want[8] && (pin_q[8] || cnt_q >= HOLD);
        cnt_q <= pin_q[8] ? 0 : cnt_q + 1;
    end
endmodule : dfd_ctl

// ---- bench/dfd_decoder_tb_top.sv ----
// self-checking bench for the input function decoder
// assumes dfd_ctl on the pins and one 20 MHz clock
`timescale 1ns/1ps
`include "dfd_map.svh"
module dfd_decoder_tb_top;
    logic clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, run = 1'b0, dlim = 1'b0, kreq = 1'b0, lreq = 1'b0;
    logic [1:0] clm = 2'h0, tqm = 2'h0;
    logic [8:0] want = 9'h100, term, ur;
    logic [53:0] func = {`DFD_FN_STOP_NORMAL, `DFD_FN_PICKUP, `DFD_FN_UNIVERSAL, `DFD_FN_LINK_EN,
        `DFD_FN_TORQUE_CANCEL, `DFD_FN_INTERLOCK, `DFD_FN_INVERSE, `DFD_FN_PID_CANCEL, `DFD_FN_WRITE_EN};
    logic ko, cla, ainv, ipe, ipu, vtq, vfb, lok, pk, fs, f4, rs, cb, sf, al;
    int failures = 0, checks_done = 0;
    always #25 clk = ~clk;
    dfd_ctl #(.HOLD(8)) ctl (.clk(clk), .want(want), .term(term));
    dfd_decoder #(.STOP_HOLD_CYC(8)) dut (.CORE_CLK(clk), .ARST_N(arst_n), .CLK_EN(clk_en), .TERM_IN(term),
        .TERM_FUNC(func), .CLOSED_LOOP_MODE(clm), .TORQUE_CONTROL_MODE(tqm), .MOTOR_RUNNING(run),
        .DECEL_LIMIT_ACTIVE(dlim), .KEYPAD_WRITE_REQ(kreq), .LINK_CMD_REQ(lreq), .KEYPAD_WRITE_OK(ko),
        .CLOSED_LOOP_ACTIVE(cla), .ANALOG_INVERT(ainv), .IPF_DETECT_EXT(ipe), .IPF_DETECT_USE(ipu),
        .VIN_IS_TORQUE_CMD(vtq), .VIN_IS_FEEDBACK(vfb), .LINK_CMD_OK(lok), .UNIVERSAL_READ(ur),
        .PICKUP_START_EN(pk), .FORCED_STOP(fs), .FOURTH_RAMP_SEL(f4), .RAMP_STRETCH_OK(rs),
        .CMD_SOURCE_BLOCK(cb), .SECOND_FREQ_SEL(sf), .CONFIG_STOP_ALARM(al));
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // pins need five edges through the synchroniser, so eight leave margin
    task automatic wt;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask : wt
    task automatic setf(input int g, input logic [5:0] c);
        @(posedge clk);
        func[6*g +: 6] <= c;
    endtask : setf
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    task automatic t_write;
        @(posedge clk);
        kreq <= 1'b1;
        wt();
        chk(9'(ko), 9'h0);
        @(posedge clk);
        want[0] <= 1'b1;
        wt();
        chk(9'(ko), 9'h1);
        // terminal kept on while its function is moved away and back
        setf(0, `DFD_FN_UNIVERSAL);
        wt();
        chk(9'(ko), 9'h1);
        chk(ur, 9'h001);
        setf(0, `DFD_FN_WRITE_EN);
        wt();
        chk(9'(ko), 9'h1);
        $display("t_write done");
    endtask : t_write
    task automatic t_misc;
        for (int j = 0; j < 2; j++) begin
            @(posedge clk);
            lreq <= 1'b1;
            want[7:5] <= {3{j[0]}};
            want[3] <= j[0];
            wt();
            chk(9'(ipe), 9'(j[0]));
            chk(9'(ipu), 9'h1);
            chk(9'(lok), 9'(j[0]));
            chk(ur, {2'h0, j[0], 6'h0});
            chk(9'(pk), 9'(j[0]));
            chk(9'(ainv), 9'h0);
            chk(9'(al), 9'h0);
        end
        // interlock unassigned: external detection must not be used
        setf(3, `DFD_FN_PICKUP);
        wt();
        chk(9'(ipu), 9'h0);
        chk(9'(ipe), 9'h0);
        setf(3, `DFD_FN_INTERLOCK);
        $display("t_misc done");
    endtask : t_misc
    task automatic t_modes;
        logic sel, ca, tq;
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            clm <= i[1:0];
            tqm <= i[3:2];
            want[2:1] <= {1'b1, i[4]};
            want[4] <= i[5];
            wt();
            sel = clm == 2'h1 || clm == 2'h2;
            ca = sel && !i[4];
            tq = tqm == 2'h1 || tqm == 2'h2;
            chk(9'(cla), 9'(ca));
            chk(9'(ainv), 9'(!sel));
            chk(9'(vtq), 9'(tq && !i[5]));
            chk(9'(vfb), 9'(tq && i[5] && ca));
        end
        $display("t_modes done");
    endtask : t_modes
    task automatic t_freq;
        for (int k = 0; k < 4; k++) begin
            setf(6, k[1] ? `DFD_FN_FREQ_INVERTED : `DFD_FN_FREQ_NORMAL);
            @(posedge clk);
            want[6] <= k[0];
            wt();
            chk(9'(sf), 9'(k[0] ^ k[1]));
        end
        chk(9'(al), 9'h0);
        setf(7, `DFD_FN_FREQ_NORMAL);
        wt();
        chk(9'(al), 9'h1);
        setf(7, `DFD_FN_PICKUP);
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        wt();
        chk(9'(al), 9'h0);
        $display("t_freq done");
    endtask : t_freq
    task automatic t_stop;
        for (int k = 0; k < 2; k++) begin
            // reset per pass so the sticky alarm is seen to rise each time
            @(posedge clk);
            arst_n <= 1'b0;
            @(posedge clk);
            arst_n <= 1'b1;
            setf(8, k[0] ? `DFD_FN_STOP_FOURTH : `DFD_FN_STOP_NORMAL);
            wt();
            chk(9'(al), 9'h0);
            @(posedge clk);
            run <= 1'b1;
            dlim <= 1'b1;
            wt();
            chk(9'(lok), 9'h1);
            chk(9'(al), 9'h0);
            @(posedge clk);
            want[8] <= 1'b0;
            @(posedge clk);
            want[8] <= 1'b1;
            wt();
            chk(9'(fs), 9'h1);
            chk(9'(al), 9'h1);
            chk(9'(lok), 9'h0);
            chk(9'(cb), 9'h1);
            chk(9'(rs), 9'h1);
            chk(9'(f4), 9'(k[0]));
            @(posedge clk);
            run <= 1'b0;
            wt();
            chk(9'(fs), 9'h0);
        end
        $display("t_stop done");
    endtask : t_stop
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_write();
        t_misc();
        t_modes();
        t_freq();
        t_stop();
        report_and_stop();
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule : dfd_decoder_tb_top
bind dfd_decoder dfd_decoder_chk u_chk (.*);
